// File: rtl/mmrc_consts.vh
`ifndef MMRC_CONSTS_VH
`define MMRC_CONSTS_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define MMRC_IDX_FLS_STAGE   12'hFD0
`define MMRC_IDX_FLS_COMMIT  12'hFD1
`define MMRC_IDX_FLS_MON     12'hFD2
`define MMRC_IDX_MAP_STAGE   12'hFDE
`define MMRC_IDX_MAP_KEY     12'hFDF

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MMRC_BIT_RSTDIS      0
`define MMRC_BIT_RAREA       1
`define MMRC_BIT_RVCTR       2
`define MMRC_BIT_BOOTMAP     4

// ----------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------
`define MMRC_KEY_RSTDIS      8'hB2
`define MMRC_KEY_MAP         8'hD4
`define MMRC_KEY_FCLR        8'h71
`define MMRC_KEY_FLASH       8'hD5
`define MMRC_MAP_RST         3'h0
`define MMRC_FLS_RST         8'h40
`define MMRC_SWI_OPCODE      8'hFF
`define MMRC_EMPTY_DATA      8'hFF

// ----------------------------------------------------------------
// Address windows
// ----------------------------------------------------------------
`define MMRC_RAM_LO          16'h0040
`define MMRC_RAM_HI          16'h083F
`define MMRC_BOOT_LO         16'h1000
`define MMRC_BOOT_HI         16'h17FF
`define MMRC_BOOT_SER_HI     16'h1FFF
`define MMRC_FLASH_LO        16'h8000
`define MMRC_SFR1_LO         16'h0000
`define MMRC_SFR1_HI         16'h003F
`define MMRC_SFR2_LO         16'h0F00
`define MMRC_SFR2_HI         16'h0FFF
`define MMRC_SFR3_LO         16'h0E40
`define MMRC_SFR3_HI         16'h0EFF
`define MMRC_VCALL_LO        16'hFFA0
`define MMRC_VCALL_HI        16'hFFBF
`define MMRC_VINT_LO         16'hFFCC
`define MMRC_VINT_HI         16'hFFFD
`define MMRC_VREL_MASK       16'h01FF

// ----------------------------------------------------------------
// Region codes
// ----------------------------------------------------------------
`define MMRC_REG_NONE        3'h0
`define MMRC_REG_SFR         3'h1
`define MMRC_REG_RAM         3'h2
`define MMRC_REG_BOOT        3'h3
`define MMRC_REG_FLASH       3'h4
`define MMRC_REG_SWI         3'h5
`define MMRC_REG_FF          3'h6

`endif

// File: rtl/mmrc_decode.v
`include "mmrc_consts.vh"

module mmrc_decode (
  // Request
  input  wire        i_is_code,
  input  wire [15:0] i_addr,
  // Committed mapping, mode and configuration
  input  wire        i_ram_code_map,
  input  wire        i_vec_reloc,
  input  wire        i_boot_map,
  input  wire        i_serial_mode,
  input  wire        i_flash_large,
  // Result
  output reg  [2:0]  o_region,
  output reg  [15:0] o_addr
);

  // ----------------------------------------------------------------
  // Window decode
  // ----------------------------------------------------------------
  reg        in_vec;
  reg [15:0] boot_hi;

  // One space decoded combinationally; caller registers the result
  always @* begin
    in_vec   = 1'b0;
    boot_hi  = i_serial_mode ? `MMRC_BOOT_SER_HI : `MMRC_BOOT_HI;
    o_addr   = i_addr;
    o_region = `MMRC_REG_NONE;
    if (i_is_code) begin
      // Reset vector at top two bytes stays fixed
      in_vec = (i_addr >= `MMRC_VCALL_LO && i_addr <= `MMRC_VCALL_HI) ||
               (i_addr >= `MMRC_VINT_LO && i_addr <= `MMRC_VINT_HI);
      if (i_vec_reloc && in_vec) begin
        o_addr   = i_addr & `MMRC_VREL_MASK;
        o_region = (i_ram_code_map || i_serial_mode) ? `MMRC_REG_RAM : `MMRC_REG_SWI;
      end else if (i_addr >= `MMRC_RAM_LO && i_addr <= `MMRC_RAM_HI) begin
        o_region = (i_ram_code_map || i_serial_mode) ? `MMRC_REG_RAM : `MMRC_REG_SWI;
      end else if (i_addr >= `MMRC_BOOT_LO && i_addr <= boot_hi) begin
        if (i_boot_map)
          o_region = `MMRC_REG_BOOT;
        else
          o_region = i_flash_large ? `MMRC_REG_FLASH : `MMRC_REG_SWI;
      end else if (i_addr >= `MMRC_FLASH_LO) begin
        o_region = `MMRC_REG_FLASH;
      end else begin
        o_region = i_flash_large ? `MMRC_REG_FLASH : `MMRC_REG_SWI;
      end
    end else begin
      if (i_addr <= `MMRC_SFR1_HI ||
          (i_addr >= `MMRC_SFR2_LO && i_addr <= `MMRC_SFR2_HI) ||
          (i_addr >= `MMRC_SFR3_LO && i_addr <= `MMRC_SFR3_HI))
        o_region = `MMRC_REG_SFR;
      else if (i_addr >= `MMRC_RAM_LO && i_addr <= `MMRC_RAM_HI)
        o_region = `MMRC_REG_RAM;
      else if (i_addr >= `MMRC_BOOT_LO && i_addr <= boot_hi)
        o_region = i_boot_map ? `MMRC_REG_BOOT : `MMRC_REG_FF;
      else if (i_addr >= `MMRC_FLASH_LO)
        o_region = `MMRC_REG_FLASH;
    end
  end

endmodule

// File: rtl/mmrc_top.v
// Functional notes
// - Code fetches and data accesses decode in two separate 64-Kbyte spaces.
// - RAM sits at 0x0040-0x083F in data space from reset.
// - Outside serial mode, RAM enters code space only after mapping bit set and 0xD4 committed.
// - Relocation bit moves vector tables from 0xFFxx to 0x01xx.
// - Reset vector never relocates.
// - Serial programming mode always maps RAM into code space.
// - Unmapped RAM window fetches return the software interrupt opcode.
// - Staging register holds relocation, RAM map, reset-disable bits; upper bits zero.
// - Keys 0xB2 and 0xD4 commit their staged values; 0x71 pulses the reset flag clear; others ignored.
// - Key write and status read share one address; no read-modify-write.
// - Status shows committed relocation, RAM map, reset-disable bits.
// - Boot ROM unmapped at reset; mapped at 0x1000-0x17FF after 0xD5 commit.
// - Outside serial mode only the first 2 Kbytes of boot ROM show.
// - Unmapped boot window fetches go to flash or software interrupt opcode.
// - Flash control staging is double-buffered; active value readable in monitor.
// - Flash commit register accepts 0xD5; other values do nothing.
// - Flash sits at 0x8000-0xFFFF in code space from reset.
// - Three special-function windows decode in data space from reset.
// - RAM contents are never initialised by hardware.
// - Unmapped boot window data reads return 0xFF.
// - Flash sits at 0x8000-0xFFFF in data space from reset.
//
// Design decision made here: the APB register port.
`include "mmrc_consts.vh"

module mmrc_top (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_rst_b,
  // APB slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [15:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output wire        o_pready,
  output wire        o_pslverr,
  // CPU fetch bus
  input  wire [15:0] i_fetch_addr,
  output reg  [2:0]  o_fetch_region,
  output reg  [15:0] o_fetch_addr,
  output reg  [7:0]  o_fetch_fill,
  // CPU data bus
  input  wire [15:0] i_data_addr,
  output reg  [2:0]  o_data_region,
  output reg  [15:0] o_data_addr,
  output reg  [7:0]  o_data_fill,
  // Mode and configuration
  input  wire        i_serial_mode,
  input  wire        i_flash_large,
  // Committed controls
  output reg         o_reset_disable,
  output reg         o_reset_flag_clear,
  output reg  [7:0]  o_flash_control_active
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg  [2:0]  map_control_staging;
  reg  [7:0]  flash_control_staging;
  reg         ram_code_map_state;
  reg         vector_relocate_state;
  reg         serial_meta;
  reg         serial_sync;
  wire [11:0] reg_idx;
  wire        apb_setup;
  wire        apb_access;
  wire        apb_wr;
  reg         idx_hit;
  reg  [31:0] next_prdata;
  wire [7:0]  wbyte;
  wire [7:0]  map_committed_status;
  wire [2:0]  code_region;
  wire [15:0] code_addr;
  wire [2:0]  data_region;
  wire [15:0] data_addr;

  assign reg_idx    = i_paddr[13:2];
  assign apb_setup  = i_psel & ~i_penable;
  assign apb_access = i_psel & i_penable;
  assign wbyte      = i_pwdata[7:0];
  assign o_pready   = 1'b1;
  assign o_pslverr  = apb_access & ~idx_hit;
  assign apb_wr     = apb_access & i_pwrite & idx_hit;
  assign map_committed_status = {5'h00, vector_relocate_state, ram_code_map_state,
                                 o_reset_disable};

  // ----------------------------------------------------------------
  // Serial mode synchroniser
  // ----------------------------------------------------------------

  // Two flops before any decode logic reads the mode pin
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      serial_meta <= 1'b0;
      serial_sync <= 1'b0;
    end else begin
      serial_meta <= i_serial_mode;
      serial_sync <= serial_meta;
    end
  end

  // ----------------------------------------------------------------
  // Address decode and read mux
  // ----------------------------------------------------------------

  // Register hit and read data, byte in the low lanes
  always @* begin
    idx_hit     = 1'b1;
    next_prdata = 32'h0000_0000;
    if (i_paddr[15:14] != 2'h0 || i_paddr[1:0] != 2'h0) begin
      idx_hit = 1'b0;
    end else if (reg_idx == `MMRC_IDX_FLS_STAGE) begin
      next_prdata[7:0] = flash_control_staging;
    end else if (reg_idx == `MMRC_IDX_FLS_COMMIT) begin
      next_prdata[7:0] = 8'h00;
    end else if (reg_idx == `MMRC_IDX_FLS_MON) begin
      next_prdata[7:0] = o_flash_control_active;
    end else if (reg_idx == `MMRC_IDX_MAP_STAGE) begin
      next_prdata[7:0] = {5'h00, map_control_staging};
    end else if (reg_idx == `MMRC_IDX_MAP_KEY) begin
      next_prdata[7:0] = map_committed_status;
    end else begin
      idx_hit = 1'b0;
    end
  end

  // Read data captured in setup, held through access
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_prdata <= 32'h0000_0000;
    end else if (apb_setup) begin
      o_prdata <= next_prdata;
    end
  end

  // ----------------------------------------------------------------
  // Staging and commit registers
  // ----------------------------------------------------------------

  // Writes land at the access edge; commits act on that same edge
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      map_control_staging    <= `MMRC_MAP_RST;
      flash_control_staging  <= `MMRC_FLS_RST;
      ram_code_map_state     <= 1'b0;
      vector_relocate_state  <= 1'b0;
      o_reset_disable        <= 1'b0;
      o_reset_flag_clear     <= 1'b0;
      o_flash_control_active <= `MMRC_FLS_RST;
    end else begin
      o_reset_flag_clear <= 1'b0;
      if (apb_wr) begin
        if (reg_idx == `MMRC_IDX_FLS_STAGE) begin
          flash_control_staging <= wbyte;
        end else if (reg_idx == `MMRC_IDX_FLS_COMMIT) begin
          if (wbyte == `MMRC_KEY_FLASH)
            o_flash_control_active <= flash_control_staging;
        end else if (reg_idx == `MMRC_IDX_MAP_STAGE) begin
          map_control_staging <= wbyte[2:0];
        end else if (reg_idx == `MMRC_IDX_MAP_KEY) begin
          if (wbyte == `MMRC_KEY_RSTDIS) begin
            o_reset_disable <= map_control_staging[`MMRC_BIT_RSTDIS];
          end else if (wbyte == `MMRC_KEY_MAP) begin
            ram_code_map_state    <= map_control_staging[`MMRC_BIT_RAREA];
            vector_relocate_state <= map_control_staging[`MMRC_BIT_RVCTR];
          end else if (wbyte == `MMRC_KEY_FCLR) begin
            o_reset_flag_clear <= 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Space decoders
  // ----------------------------------------------------------------

  // Code space view
  mmrc_decode u_code_dec (
    .i_is_code      (1'b1),
    .i_addr         (i_fetch_addr),
    .i_ram_code_map (ram_code_map_state),
    .i_vec_reloc    (vector_relocate_state),
    .i_boot_map     (o_flash_control_active[`MMRC_BIT_BOOTMAP]),
    .i_serial_mode  (serial_sync),
    .i_flash_large  (i_flash_large),
    .o_region       (code_region),
    .o_addr         (code_addr)
  );

  // Data space view
  mmrc_decode u_data_dec (
    .i_is_code      (1'b0),
    .i_addr         (i_data_addr),
    .i_ram_code_map (ram_code_map_state),
    .i_vec_reloc    (vector_relocate_state),
    .i_boot_map     (o_flash_control_active[`MMRC_BIT_BOOTMAP]),
    .i_serial_mode  (serial_sync),
    .i_flash_large  (i_flash_large),
    .o_region       (data_region),
    .o_addr         (data_addr)
  );

  // ----------------------------------------------------------------
  // Registered decode outputs
  // ----------------------------------------------------------------

  // One cycle after the address; RAM itself is never cleared here
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_fetch_region <= `MMRC_REG_NONE;
      o_fetch_addr   <= 16'h0000;
      o_fetch_fill   <= 8'h00;
      o_data_region  <= `MMRC_REG_NONE;
      o_data_addr    <= 16'h0000;
      o_data_fill    <= 8'h00;
    end else begin
      o_fetch_region <= code_region;
      o_fetch_addr   <= code_addr;
      o_fetch_fill   <= (code_region == `MMRC_REG_SWI) ? `MMRC_SWI_OPCODE : 8'h00;
      o_data_region  <= data_region;
      o_data_addr    <= data_addr;
      o_data_fill    <= (data_region == `MMRC_REG_FF) ? `MMRC_EMPTY_DATA : 8'h00;
    end
  end

endmodule

// File: sim/mmrc_chk_properties.sv
// ----
// Checker on the top ports
// ----
module mmrc_chk (
  input logic        i_clk,
  input logic        i_rst_b,
  input logic        i_psel,
  input logic        i_penable,
  input logic        i_pwrite,
  input logic [15:0] i_paddr,
  input logic [31:0] i_pwdata,
  input logic [15:0] i_fetch_addr,
  input logic [2:0]  o_fetch_region,
  input logic [15:0] o_fetch_addr,
  input logic [7:0]  o_fetch_fill,
  input logic [15:0] i_data_addr,
  input logic [2:0]  o_data_region,
  input logic [15:0] o_data_addr,
  input logic [7:0]  o_data_fill,
  input logic        o_reset_disable,
  input logic        o_reset_flag_clear,
  input logic [7:0]  o_flash_control_active
);
  timeunit 1ns;
  timeprecision 1ps;
  logic kw;
  logic fc;
  // Key and flash commit writes
  assign kw = i_psel && i_penable && i_pwrite && i_paddr == 16'h3F7C;
  assign fc = i_psel && i_penable && i_pwrite && i_paddr == 16'h3F44 && i_pwdata[7:0] == 8'hD5;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  chk_data_ram: assert property (i_data_addr inside {[16'h0040:16'h083F]} |=> o_data_region == 3'h2)
    else $error("data RAM window misdecoded");
  chk_data_pass: assert property (1'b1 |=> o_data_addr == $past(i_data_addr))
    else $error("data address altered");
  chk_sfr_win: assert property (i_data_addr inside {[16'h0000:16'h003F], [16'h0E40:16'h0FFF]}
    |=> o_data_region == 3'h1)
    else $error("special window misdecoded");
  chk_flash_code: assert property (i_fetch_addr inside {[16'h8000:16'hFF9F]} |=> o_fetch_region == 3'h4)
    else $error("code flash misdecoded");
  chk_reset_vec: assert property (i_fetch_addr >= 16'hFFFE
    |=> o_fetch_region == 3'h4 && o_fetch_addr == $past(i_fetch_addr))
    else $error("reset vector moved");
  chk_swi_fill: assert property (o_fetch_fill == ((o_fetch_region == 3'h5) ? 8'hFF : 8'h00))
    else $error("fetch fill mismatch");
  chk_boot_empty: assert property (i_data_addr inside {[16'h1000:16'h17FF]} && !o_flash_control_active[4]
    |=> o_data_region == 3'h6 && o_data_fill == 8'hFF)
    else $error("unmapped boot read not empty");
  chk_flag_pulse: assert property (kw && i_pwdata[7:0] == 8'h71 |=> o_reset_flag_clear)
    else $error("flag clear not pulsed");
  chk_rstdis_key: assert property ($changed(o_reset_disable) |-> $past(kw && i_pwdata[7:0] == 8'hB2))
    else $error("reset disable changed without key");
  chk_flash_hold: assert property (!fc |=> $stable(o_flash_control_active))
    else $error("flash active changed without commit");
endmodule

bind mmrc_top mmrc_chk i_mmrc_chk (.i_clk, .i_rst_b, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
  .i_fetch_addr, .o_fetch_region, .o_fetch_addr, .o_fetch_fill, .i_data_addr, .o_data_region, .o_data_addr,
  .o_data_fill, .o_reset_disable, .o_reset_flag_clear, .o_flash_control_active);

// File: sim/mmrc_cpu_model.sv
// ----
// CPU core bus model
// ----
module mmrc_cpu_model (
  input  logic        i_clk,
  input  logic [15:0] i_fetch_want,
  input  logic [15:0] i_data_want,
  output logic [15:0] o_fetch_addr,
  output logic [15:0] o_data_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  // Presents fetch and data addresses on separate buses after an edge
  always @(posedge i_clk) begin
    o_fetch_addr <= i_fetch_want;
    o_data_addr  <= i_data_want;
  end
endmodule

// File: sim/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk = 0, i_rst_b = 0, psel = 0, pen = 0, pwr = 0, ser = 0, big = 0, rdy, err, se, rdis, fclr;
  logic [15:0] pa = 0, fw = 0, dw = 0, fa, da, foa, doa;
  logic [31:0] pwd = 0, prd, r;
  logic [2:0]  freg, dreg;
  logic [7:0]  ff, df, fact;
  int          err_total = 0, n_compared = 0;
  // Decode rows: space, address, region, address out
  logic [39:0] rows [14] = '{40'h0_0040_2_0040, 40'h0_083F_2_083F, 40'h0_0840_0_0840, 40'h0_003F_1_003F,
    40'h0_0E40_1_0E40, 40'h0_0FFF_1_0FFF, 40'h0_1000_6_1000, 40'h0_8000_4_8000, 40'h1_0040_5_0040,
    40'h1_083F_5_083F, 40'h1_1000_5_1000, 40'h1_8000_4_8000, 40'h1_FFA0_4_FFA0, 40'h1_FFFF_4_FFFF};
  initial forever #2 i_clk = ~i_clk;
  mmrc_top i_mmrc_top (.i_clk, .i_rst_b, .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa),
    .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(err), .i_fetch_addr(fa), .o_fetch_region(freg),
    .o_fetch_addr(foa), .o_fetch_fill(ff), .i_data_addr(da), .o_data_region(dreg), .o_data_addr(doa),
    .o_data_fill(df), .i_serial_mode(ser), .i_flash_large(big), .o_reset_disable(rdis),
    .o_reset_flag_clear(fclr), .o_flash_control_active(fact));
  mmrc_cpu_model i_mmrc_cpu_model (.i_clk, .i_fetch_want(fw), .i_data_want(dw), .o_fetch_addr(fa),
    .o_data_addr(da));
  // ----
  // Tasks
  // ----
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    @(posedge i_clk);
    psel <= 1; pen <= 0; pwr <= w; pa <= a; pwd <= {24'h0, d};
    @(posedge i_clk);
    pen <= 1;
    n = 0;
    do begin @(posedge i_clk); n++; end while (rdy !== 1'b1 && n < 50);
    r = prd; se = err; psel <= 0; pen <= 0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    apb(0, a, 8'h00);
    chk(r, {24'h0, e});
  endtask
  task automatic dec(input logic c, input logic [15:0] a, input logic [2:0] er, input logic [15:0] ea);
    @(posedge i_clk);
    if (c) fw <= a; else dw <= a;
    repeat (2) @(posedge i_clk);
    #1;
    if (c) begin
      chk(freg, er);
      chk(foa, ea);
      chk(ff, (er == 3'h5) ? 8'hFF : 8'h00);
    end else begin
      chk(dreg, er);
      chk(doa, ea);
      chk(df, (er == 3'h6) ? 8'hFF : 8'h00);
    end
  endtask
  task automatic wrap_up;
    if (err_total == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----
  // Watchdog
  // ----
  initial begin
    #40000;
    err_total++;
    wrap_up();
  end
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (6) @(posedge i_clk);
    i_rst_b <= 1;
    rd(16'h3F7C, 8'h00);
    rd(16'h3F78, 8'h00);
    rd(16'h3F48, 8'h40);
    apb(0, 16'h3F80, 8'h00);
    chk(se, 1);
    foreach (rows[i]) dec(rows[i][36], rows[i][35:20], rows[i][18:16], rows[i][15:0]);
    @(posedge i_clk) big <= 1;
    dec(1, 16'h1000, 3'h4, 16'h1000);
    apb(1, 16'h3F78, 8'hFF);
    rd(16'h3F78, 8'h07);
    rd(16'h3F7C, 8'h00);
    dec(1, 16'h0100, 3'h5, 16'h0100);
    apb(1, 16'h3F7C, 8'h55);
    rd(16'h3F7C, 8'h00);
    apb(1, 16'h3F7C, 8'hD4);
    rd(16'h3F7C, 8'h06);
    chk(rdis, 0);
    dec(1, 16'h0100, 3'h2, 16'h0100);
    dec(1, 16'hFFA0, 3'h2, 16'h01A0);
    dec(1, 16'hFFFD, 3'h2, 16'h01FD);
    dec(1, 16'hFFFE, 3'h4, 16'hFFFE);
    apb(1, 16'h3F7C, 8'hB2);
    rd(16'h3F7C, 8'h07);
    chk(rdis, 1);
    apb(1, 16'h3F7C, 8'h71);
    #1;
    chk(fclr, 1);
    apb(1, 16'h3F40, 8'h50);
    rd(16'h3F48, 8'h40);
    dec(0, 16'h1000, 3'h6, 16'h1000);
    apb(1, 16'h3F44, 8'hD5);
    rd(16'h3F48, 8'h50);
    dec(0, 16'h1000, 3'h3, 16'h1000);
    dec(1, 16'h17FF, 3'h3, 16'h17FF);
    dec(1, 16'h1800, 3'h4, 16'h1800);
    @(posedge i_clk) i_rst_b <= 0;
    repeat (6) @(posedge i_clk);
    i_rst_b <= 1;
    ser <= 1;
    rd(16'h3F7C, 8'h00);
    rd(16'h3F48, 8'h40);
    chk(rdis, 0);
    dec(1, 16'h0100, 3'h2, 16'h0100);
    wrap_up();
  end
endmodule
